// ### logic/uwr_baud_gen.sv
// Baud divisor counter with x16 / x64 prescale giving the 16x sample tick
`timescale 1ns/10ps
module uwr_baud_gen (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic [15:0] divisor,
  input wire logic wide,
  input wire logic high_speed,
  output logic tick16
);
  import uwr_pkg::*;
  logic [15:0] cnt_r;
  logic [1:0] pre_r;
  logic [15:0] reload;
  logic brg_tick;
  logic x64;
  assign reload = wide ? divisor : {BYTE_ZERO, divisor[7:0]};
  assign brg_tick = run && (cnt_r == DIV_RST);
  assign x64 = ~wide & ~high_speed;
  // ==========================================
  // Divisor counter; stopped while not running
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt_r <= DIV_RST;
    else if (ce)
    begin
      if (!run || brg_tick)
        cnt_r <= reload;
      else
        cnt_r <= cnt_r - 16'h0001;
    end
  end
  // ==========================================
  // In x64 mode four divisor ticks make one sample tick
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pre_r <= PRE_ZERO;
    else if (ce)
    begin
      if (!run || !x64)
        pre_r <= PRE_ZERO;
      else if (brg_tick)
        pre_r <= pre_r + 2'h1;
    end
  end
  assign tick16 = brg_tick && (!x64 || pre_r == PRE_X64);
endmodule

// ### logic/uwr_edge.sv
// Line register with rising and falling edge detection
`timescale 1ns/10ps
module uwr_edge (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  import uwr_pkg::*;
  logic prev_r;
  // ==========================================
  // Idle line is high, so reset to one to avoid a false edge
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      level <= 1'b1;
      prev_r <= 1'b1;
    end
    else if (ce)
    begin
      level <= din;
      prev_r <= level;
    end
  end
  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;
endmodule

// ### logic/uwr_pkg.sv
// Package: register map, field layout, constants and types of the wake-capable UART receiver
package uwr_pkg;
  // ==========================================
  // Register indices
  localparam int ADDR_W = 3;
  localparam logic [2:0] REG_RX_STAT = 3'h0;
  localparam logic [2:0] REG_RX_DATA = 3'h1;
  localparam logic [2:0] REG_TX_STAT = 3'h2;
  localparam logic [2:0] REG_BAUD_CTL = 3'h3;
  localparam logic [2:0] REG_DIV_HI = 3'h4;
  localparam logic [2:0] REG_DIV_LO = 3'h5;
  localparam logic [2:0] REG_IRQ_CTL = 3'h6;
  // ==========================================
  // Field positions
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINE = 6;
  localparam int RS_CONTINUOUS_RX_ENABLE = 4;
  localparam int RS_ADDR_DET = 3;
  localparam int RS_FRAMING_ERROR_FLAG = 2;
  localparam int RS_OVERRUN_ERROR_FLAG = 1;
  localparam int RS_NINTH = 0;
  localparam int TS_SYNC = 4;
  localparam int TS_HIGH_SPEED = 2;
  localparam int BC_RX_IDLE = 6;
  localparam int BC_WIDE = 3;
  localparam int BC_WAKE = 1;
  localparam int IC_IRQ_EN = 0;
  localparam int IC_DONE = 1;
  // ==========================================
  // Reset values and widths
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam int DATA_W = 8;
  // ==========================================
  // Oversampling: 16 ticks per bit, sample in the middle
  localparam logic [3:0] TICK_ZERO = 4'h0;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] BITS_EIGHT = 4'h7;
  localparam logic [3:0] BITS_NINE = 4'h8;
  localparam logic [1:0] PRE_X64 = 2'h3;
  localparam logic [1:0] PRE_ZERO = 2'h0;
  // ==========================================
  // Types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uwr_bus_t;
  typedef struct packed {
    logic ninth;
    logic framing_error_flag;
    logic [DATA_W-1:0] data;
  } uwr_char_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_STOP = 5'b01000,
    ST_WAKE = 5'b10000
  } uwr_state_t;
endpackage

// ### logic/uwr_rx_top.sv
// Asynchronous UART receiver with address detect and wake-on-break monitor
// Operation
// - Line sampled by 16x tick; shift register advances once per bit.
// - Nine-bit mode captures ninth bit into status register with error flags.
// - Receive only with continuous enable; clearing it clears error flags.
// - Completed character sets done flag; interrupt only when enabled.
// - Low eight data bits are read from the data buffer register.
// - Address detect filters characters in nine-bit mode; cleared, every character is accepted.
// - In sleep the baud generator stops and normal reception halts.
// - Wake enable, baud control bit 1, idles receiver and monitors line.
// - Wake event is a falling edge on the receive line.
// - Wake event sets the receive done flag.
// - Reading the data buffer clears the wake-induced done flag.
// - Wake enable self-clears on first rising edge after wake event.
// - Frame is start, eight or nine data bits LSB first, stop.
// - Baud generator gives 16x or 64x bit rate; 64x only with high-speed and wide bits both clear.
`timescale 1ns/10ps
module uwr_rx_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sleep,
  input wire logic rx_data_pin,
  input wire uwr_pkg::uwr_bus_t bus,
  output logic [7:0] rdata,
  output logic rx_irq,
  output logic rx_done_flag
);
  import uwr_pkg::*;

  // ==========================================
  // Declarations
  logic port_enable_bit_r;
  logic nine_bit_rx_enable_r;
  logic continuous_rx_enable_r;
  logic address_detect_enable_r;
  logic framing_error_flag_r;
  logic overrun_error_flag_r;
  logic sync_mode_r;
  logic baud_high_speed_r;
  logic baud_wide_divisor_r;
  logic wake_on_break_enable_r;
  logic rx_irq_enable_r;
  logic rx_done_flag_r;
  logic woke_r;
  logic [15:0] baud_divisor_r;
  uwr_char_t buf_r;
  uwr_state_t state_r;
  logic [3:0] tick_r;
  logic [3:0] bit_r;
  logic [8:0] shift_r;
  logic [7:0] rdata_r;
  logic line;
  logic line_rise;
  logic line_fall;
  logic tick16;
  logic rx_run;
  logic brg_run;
  logic bit_edge;
  logic char_end;
  logic [7:0] char_data;
  logic char_ninth;
  logic char_pass;
  logic load_ok;
  logic load_ovr;
  logic wake_fall;
  logic wake_done;
  logic rd_data;
  logic wr_bc;

  // ==========================================
  // Line edge detection and baud generator
  uwr_edge u_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .din(rx_data_pin),
    .level(line),
    .rise(line_rise),
    .fall(line_fall)
  );

  // Generator idles in sleep and while the wake monitor owns the line
  assign brg_run = port_enable_bit_r & ~sync_mode_r & ~sleep & ~wake_on_break_enable_r;

  uwr_baud_gen u_baud (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .run(brg_run),
    .divisor(baud_divisor_r),
    .wide(baud_wide_divisor_r),
    .high_speed(baud_high_speed_r),
    .tick16(tick16)
  );

  // ==========================================
  // Receive condition and character completion
  assign rx_run = brg_run & continuous_rx_enable_r;
  assign bit_edge = tick16 && (tick_r == TICK_LAST);
  assign char_end = rx_run && (state_r == ST_STOP) && bit_edge;
  assign char_data = nine_bit_rx_enable_r ? shift_r[7:0] : shift_r[8:1];
  assign char_ninth = nine_bit_rx_enable_r & shift_r[8];
  // Address bytes carry a ninth bit of one
  assign char_pass = ~(nine_bit_rx_enable_r & address_detect_enable_r) | char_ninth;
  assign load_ok = char_end & char_pass & ~rx_done_flag_r;
  assign load_ovr = char_end & char_pass & rx_done_flag_r;
  assign wake_fall = (state_r == ST_WAKE) & ~woke_r & line_fall;
  assign wake_done = (state_r == ST_WAKE) & woke_r & line_rise;
  assign rd_data = bus.rd && (bus.addr == REG_RX_DATA);
  assign wr_bc = bus.wr && (bus.addr == REG_BAUD_CTL);

  // ==========================================
  // Receive sequencer
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state_r <= ST_IDLE;
    else if (ce)
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (wake_on_break_enable_r && port_enable_bit_r)
            state_r <= ST_WAKE;
          else if (rx_run && line_fall)
            state_r <= ST_START;
        end
        ST_START:
        begin
          if (!rx_run)
            state_r <= ST_IDLE;
          else if (tick16 && tick_r == TICK_MID)
            state_r <= line ? ST_IDLE : ST_DATA;
        end
        ST_DATA:
        begin
          if (!rx_run)
            state_r <= ST_IDLE;
          else if (bit_edge && bit_r == (nine_bit_rx_enable_r ? BITS_NINE : BITS_EIGHT))
            state_r <= ST_STOP;
        end
        ST_STOP:
        begin
          if (!rx_run || bit_edge)
            state_r <= ST_IDLE;
        end
        ST_WAKE:
        begin
          if (wake_done || !wake_on_break_enable_r)
            state_r <= ST_IDLE;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Oversample counter and bit shifter
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tick_r <= TICK_ZERO;
      bit_r <= TICK_ZERO;
      shift_r <= 9'h000;
    end
    else if (ce)
    begin
      if (state_r == ST_IDLE || state_r == ST_WAKE)
      begin
        tick_r <= TICK_ZERO;
        bit_r <= TICK_ZERO;
      end
      else if (tick16)
      begin
        // Restart count at mid start bit so later samples land mid bit
        if (state_r == ST_START && tick_r == TICK_MID)
          tick_r <= TICK_ZERO;
        else
          tick_r <= tick_r + 4'h1;
        if (state_r == ST_DATA && tick_r == TICK_LAST)
        begin
          shift_r <= {line, shift_r[8:1]};
          bit_r <= bit_r + 4'h1;
        end
      end
    end
  end

  // ==========================================
  // Receive buffer and error flags
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      buf_r <= '0;
    else if (ce && load_ok)
    begin
      buf_r.data <= char_data;
      buf_r.ninth <= char_ninth;
      buf_r.framing_error_flag <= ~line;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      framing_error_flag_r <= 1'b0;
      overrun_error_flag_r <= 1'b0;
    end
    else if (ce)
    begin
      // Overrun drops the new character; software recovers by toggling enable
      if (load_ovr)
        overrun_error_flag_r <= 1'b1;
      else if (!continuous_rx_enable_r)
        overrun_error_flag_r <= 1'b0;
      if (load_ok)
        framing_error_flag_r <= ~line;
      else if (!continuous_rx_enable_r)
        framing_error_flag_r <= 1'b0;
    end
  end

  // ==========================================
  // Done flag: set beats clear by a read in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rx_done_flag_r <= 1'b0;
    else if (ce)
    begin
      if (load_ok || wake_fall)
        rx_done_flag_r <= 1'b1;
      else if (rd_data)
        rx_done_flag_r <= 1'b0;
    end
  end

  // ==========================================
  // Wake monitor
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      woke_r <= 1'b0;
    else if (ce)
    begin
      if (wake_fall)
        woke_r <= 1'b1;
      else if (wake_done || state_r != ST_WAKE)
        woke_r <= 1'b0;
    end
  end

  // ==========================================
  // Control registers; a software write to baud control beats the self-clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      port_enable_bit_r <= 1'b0;
      nine_bit_rx_enable_r <= 1'b0;
      continuous_rx_enable_r <= 1'b0;
      address_detect_enable_r <= 1'b0;
      sync_mode_r <= 1'b0;
      baud_high_speed_r <= 1'b0;
      baud_wide_divisor_r <= 1'b0;
      wake_on_break_enable_r <= 1'b0;
      rx_irq_enable_r <= 1'b0;
      baud_divisor_r <= DIV_RST;
    end
    else if (ce)
    begin
      if (bus.wr)
      begin
        unique case (bus.addr)
          REG_RX_STAT:
          begin
            port_enable_bit_r <= bus.wdata[RS_PORT_EN];
            nine_bit_rx_enable_r <= bus.wdata[RS_NINE];
            continuous_rx_enable_r <= bus.wdata[RS_CONTINUOUS_RX_ENABLE];
            address_detect_enable_r <= bus.wdata[RS_ADDR_DET];
          end
          REG_TX_STAT:
          begin
            sync_mode_r <= bus.wdata[TS_SYNC];
            baud_high_speed_r <= bus.wdata[TS_HIGH_SPEED];
          end
          REG_BAUD_CTL:
          begin
            baud_wide_divisor_r <= bus.wdata[BC_WIDE];
            wake_on_break_enable_r <= bus.wdata[BC_WAKE];
          end
          REG_DIV_HI:
            baud_divisor_r[15:8] <= bus.wdata;
          REG_DIV_LO:
            baud_divisor_r[7:0] <= bus.wdata;
          REG_IRQ_CTL:
            rx_irq_enable_r <= bus.wdata[IC_IRQ_EN];
          default:
          begin
          end
        endcase
      end
      if (wake_done && !wr_bc)
        wake_on_break_enable_r <= 1'b0;
    end
  end

  // ==========================================
  // Read port: data stand one cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdata_r <= BYTE_ZERO;
    else if (ce)
    begin
      rdata_r <= BYTE_ZERO;
      if (bus.rd)
      begin
        unique case (bus.addr)
          REG_RX_STAT:
            rdata_r <= {port_enable_bit_r, nine_bit_rx_enable_r, 1'b0, continuous_rx_enable_r,
                        address_detect_enable_r, framing_error_flag_r, overrun_error_flag_r,
                        buf_r.ninth};
          REG_RX_DATA:
            rdata_r <= buf_r.data;
          REG_TX_STAT:
            rdata_r <= {3'h0, sync_mode_r, 1'b0, baud_high_speed_r, 2'h0};
          REG_BAUD_CTL:
            rdata_r <= {1'b0, state_r == ST_IDLE, 2'h0, baud_wide_divisor_r, 1'b0,
                        wake_on_break_enable_r, 1'b0};
          REG_DIV_HI:
            rdata_r <= baud_divisor_r[15:8];
          REG_DIV_LO:
            rdata_r <= baud_divisor_r[7:0];
          REG_IRQ_CTL:
            rdata_r <= {6'h00, rx_done_flag_r, rx_irq_enable_r};
          default:
            rdata_r <= BYTE_ZERO;
        endcase
      end
    end
  end

  assign rdata = rdata_r;
  assign rx_done_flag = rx_done_flag_r;
  assign rx_irq = rx_done_flag_r & rx_irq_enable_r;

  // ==========================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n || !ce);

  sequence s_wake_armed;
    state_r == ST_WAKE && !woke_r && line_fall;
  endsequence

  sequence s_wake_end;
    state_r == ST_WAKE && woke_r && line_rise && !wr_bc;
  endsequence

  irq_gate_a: assert property (rx_irq |-> rx_irq_enable_r && rx_done_flag_r)
    else $error("interrupt without enable or flag");
  load_flag_a: assert property (load_ok |=> rx_done_flag_r && buf_r.data == $past(char_data))
    else $error("completed character not loaded");
  ninth_bit_a: assert property (load_ok && nine_bit_rx_enable_r |=> buf_r.ninth == $past(shift_r[8]))
    else $error("ninth bit not captured");
  addr_filter_a: assert property (char_end && nine_bit_rx_enable_r && address_detect_enable_r && !shift_r[8]
    |=> $stable(buf_r) && rx_done_flag_r == ($past(rx_done_flag_r) && !$past(rd_data)))
    else $error("data character passed address filter");
  error_clear_a: assert property (!continuous_rx_enable_r ##1 !continuous_rx_enable_r
    |-> !overrun_error_flag_r && !framing_error_flag_r)
    else $error("error flag held while receive disabled");
  overrun_a: assert property (load_ovr |=> overrun_error_flag_r && $stable(buf_r.data))
    else $error("overrun not flagged");
  wake_flag_a: assert property (s_wake_armed |=> rx_done_flag_r && woke_r)
    else $error("wake event did not set flag");
  wake_clear_a: assert property (s_wake_end |=> !wake_on_break_enable_r && state_r == ST_IDLE)
    else $error("wake enable not self-cleared");
  wake_idle_a: assert property (wake_on_break_enable_r && port_enable_bit_r
    |-> ##[0:2] state_r == ST_WAKE ##0 !tick16)
    else $error("receiver active while wake enabled");
  sleep_hold_a: assert property (sleep && !wake_on_break_enable_r
    |-> (!tick16 && !char_end) ##1 state_r == ST_IDLE)
    else $error("reception advanced in sleep");
endmodule

// ### sim/uwr_rx_top_bench.sv
// Self-checking bench for the wake-capable UART receiver
`timescale 1ns/10ps
module uwr_rx_top_bench;
  import uwr_pkg::*;
  // ==========================================
  // Clock, reset and wiring
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic sleep = 1'b0;
  logic rx_line;
  uwr_bus_t bus = '0;
  logic [7:0] rdata;
  logic rx_irq;
  logic rx_done_flag;
  logic [7:0] rd_v;
  int per = 32;
  int bad_count = 0;
  int checked = 0;
  always #2 mclk = ~mclk;
  uwr_rx_top uwr_rx_top_i (.mclk(mclk), .rst_n(rst_n), .ce(ce), .sleep(sleep),
    .rx_data_pin(rx_line), .bus(bus), .rdata(rdata), .rx_irq(rx_irq), .rx_done_flag(rx_done_flag));
  uwr_tx_model uwr_tx_model_i (.mclk(mclk), .line(rx_line));
  // ==========================================
  // Shared tasks
  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic settle;
    @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    bus <= '{addr: a, wdata: BYTE_ZERO, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 rd_v = rdata;
  endtask
  task automatic cfg(input logic [7:0] ts, input logic [7:0] bc, input logic [7:0] lo, input int p);
    wr(REG_DIV_HI, 8'h00);
    wr(REG_DIV_LO, lo);
    wr(REG_BAUD_CTL, bc);
    wr(REG_TX_STAT, ts);
    per = p;
    rd(REG_DIV_LO);
    check(rd_v, lo, "divisor readback");
  endtask
  // Status is read before the buffer so the ninth bit matches the byte
  task automatic frame(input logic [7:0] rs, input logic [8:0] d, input int nb, input logic exp);
    wr(REG_RX_STAT, rs);
    uwr_tx_model_i.send(d, nb, per, 1'b1);
    settle;
    check(rx_done_flag, exp, "done flag");
    if (exp)
    begin
      rd(REG_RX_STAT);
      check(rd_v, rs | {7'h00, d[8] & (nb == 9)}, "status");
      rd(REG_RX_DATA);
      check(rd_v, d[7:0], "data byte");
      check(rx_done_flag, 1'b0, "flag after read");
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    wr(REG_RX_DATA, 8'h5a);
    for (int i = 0; i < 8; i++)
    begin
      rd(i[2:0]);
      check(rd_v, (i == REG_BAUD_CTL) ? 8'h01 << BC_RX_IDLE : REG_RST, "reset or unmapped value");
    end
    check(rx_done_flag, 1'b0, "flag after reset");
    @(posedge mclk);
    ce <= 1'b0;
    wr(REG_DIV_LO, 8'h3c);
    ce <= 1'b1;
    rd(REG_DIV_LO);
    check(rd_v, REG_RST, "write while clock held");
    $display("reset test done");
  endtask
  task automatic t_rx;
    cfg(8'h04, 8'h00, 8'h01, 32);
    frame(8'h90, 9'h04b, 8, 1'b1);
    frame(8'h90, 9'h0d2, 8, 1'b1);
    frame(8'hd0, 9'h1c3, 9, 1'b1);
    frame(8'hd0, 9'h03c, 9, 1'b1);
    frame(8'hd8, 9'h055, 9, 1'b0);
    frame(8'hd8, 9'h1a7, 9, 1'b1);
    frame(8'hd0, 9'h066, 9, 1'b1);
    frame(8'h80, 9'h0ff, 8, 1'b0);
    wr(REG_TX_STAT, 8'h14);
    frame(8'h90, 9'h0ff, 8, 1'b0);
    cfg(8'h00, 8'h00, 8'h00, 64);
    frame(8'h90, 9'h0e1, 8, 1'b1);
    cfg(8'h00, 8'h08, 8'h01, 32);
    frame(8'h90, 9'h01e, 8, 1'b1);
    $display("receive test done");
  endtask
  task automatic t_err;
    wr(REG_IRQ_CTL, 8'h00);
    uwr_tx_model_i.send(9'h0f0, 8, per, 1'b0);
    settle;
    check(rx_irq, 1'b0, "irq while masked");
    wr(REG_IRQ_CTL, 8'h01);
    settle;
    check(rx_irq, 1'b1, "irq enabled");
    rd(REG_RX_STAT);
    check(rd_v & 8'h04, 8'h04, "framing flag");
    uwr_tx_model_i.send(9'h011, 8, per, 1'b1);
    rd(REG_RX_STAT);
    check(rd_v & 8'h02, 8'h02, "overrun flag");
    rd(REG_RX_DATA);
    check(rd_v, 8'hf0, "buffer kept");
    check(rx_irq, 1'b0, "irq after read");
    wr(REG_RX_STAT, 8'h80);
    wr(REG_RX_STAT, 8'h90);
    rd(REG_RX_STAT);
    check(rd_v, 8'h90, "errors cleared");
    wr(REG_IRQ_CTL, 8'h00);
    $display("error test done");
  endtask
  task automatic t_wake;
    for (int s = 0; s < 2; s++)
    begin
      @(posedge mclk);
      sleep <= s[0];
      uwr_tx_model_i.send(9'h0aa, 8, per, 1'b1);
      settle;
      check(rx_done_flag, !s[0], "frame with sleep");
      rd(REG_RX_DATA);
      wr(REG_BAUD_CTL, 8'h0a);
      fork
        uwr_tx_model_i.brk(12, per);
        begin
          repeat (8) @(posedge mclk);
          #1 check(rx_done_flag, 1'b1, "wake flag");
          rd(REG_BAUD_CTL);
          check(rd_v & 8'h02, 8'h02, "wake bit held");
        end
      join
      rd(REG_BAUD_CTL);
      check(rd_v & 8'h02, 8'h00, "wake bit cleared");
      rd(REG_RX_STAT);
      check(rd_v & 8'h04, 8'h00, "no frame during wake");
      rd(REG_RX_DATA);
      check(rx_done_flag, 1'b0, "wake flag read");
      @(posedge mclk);
      sleep <= 1'b0;
    end
    frame(8'h90, 9'h0c5, 8, 1'b1);
    $display("wake test done");
  endtask
  // ==========================================
  // Sequence, watchdog and verdict
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_rx;
    t_err;
    t_wake;
    test_done;
  end
  // The tests need about 7400 cycles, so this leaves ample margin
  initial
  begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done;
  end
endmodule

// ### sim/uwr_tx_model.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/10ps
module uwr_tx_model (
  input wire logic mclk,
  output logic line
);
  // ==========================================
  // Line driver
  // The line is driven at all times and rests high between frames
  initial line = 1'b1;
  task automatic hold(input logic lvl, input int n);
    @(posedge mclk);
    line <= lvl;
    repeat (n - 1) @(posedge mclk);
  endtask
  // ==========================================
  // Frames
  task automatic send(input logic [8:0] d, input int nbits, input int per, input logic stop);
    hold(1'b0, per);
    for (int i = 0; i < nbits; i++)
      hold(d[i], per);
    hold(stop, per);
    hold(1'b1, per);
  endtask
  // Any edge inside the wake character would end it early, so it is all zeros
  task automatic brk(input int nbits, input int per);
    hold(1'b0, nbits * per);
    hold(1'b1, 4 * per);
  endtask
endmodule
